// ===== hw/wkid_defines.svh
// Constants for the wake-up and interrupt dispatch block
`ifndef WKID_DEFINES_SVH
`define WKID_DEFINES_SVH
`define WKID_VECTOR_ADDR      8'h08
`define WKID_ADDR_IRQ_ENABLE  12'h000
`define WKID_ADDR_WAKE_CTRL   12'h004
`define WKID_ADDR_FLAGS       12'h008
`define WKID_ADDR_STATUS      12'h00c
`define WKID_ADDR_MASK        12'h010
`define WKID_ADDR_MODE        12'h014
`define WKID_BIT_TMR_IE       0
`define WKID_BIT_PC_IE        1
`define WKID_BIT_EXT_IE       2
`define WKID_BIT_PC_WE        4
`define WKID_BIT_F_TMR        0
`define WKID_BIT_F_PC         1
`define WKID_BIT_F_EXT0       2
`define WKID_BIT_F_EXT1       3
`define WKID_BIT_MODE_GIE     2
`define WKID_RESET_BYTE       8'h00
`endif

// ===== hw/wkid_dispatch.sv
// Wake-up and interrupt dispatch with APB register slave
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "wkid_defines.svh"
module wkid_dispatch
  import wkid_pkg::*;
(
  input  wire logic         core_clk_in,
  input  wire logic         arst_n_in,
  input  wire logic         psel_in,
  input  wire logic         penable_in,
  input  wire logic         pwrite_in,
  input  wire logic [11:0]  paddr_in,
  input  wire logic [31:0]  pwdata_in,
  output logic      [31:0]  prdata_out,
  output logic              pready_out,
  output logic              pslverr_out,
  input  wire wkid_events_s events_in,
  input  wire logic         sleep_op_in,
  input  wire logic         idle_op_in,
  input  wire logic         resume_in,
  output wkid_dispatch_s    dispatch_out,
  output logic              osc_run_out,
  output logic              timer_run_out,
  output logic              irq_out
);

  // Registers written by software, hardware-set flags and status, and the power mode
  logic [7:0]  irq_enable;
  logic [7:0]  wake_ctrl;
  logic [3:0]  flags;
  logic [3:0]  status;
  logic [3:0]  mask;
  logic        gie;
  logic        green;
  wkid_mode_e  mode;

  // Decoded single bits
  wire logic ext_pin_irq_enable        = irq_enable[`WKID_BIT_EXT_IE];
  wire logic port_change_irq_enable    = irq_enable[`WKID_BIT_PC_IE];
  wire logic timer_overflow_irq_enable = irq_enable[`WKID_BIT_TMR_IE];
  wire logic port_change_wake_enable   = wake_ctrl[`WKID_BIT_PC_WE];
  wire logic in_sleep  = (mode == WKID_SLEEP);
  wire logic in_idle   = (mode == WKID_IDLE);
  wire logic asleep    = in_sleep | in_idle;
  wire logic ext_evt   = events_in.ext_pin_0 | events_in.ext_pin_1;

  // APB decode; zero-wait slave, so the read word is latched in the setup cycle
  wire logic acc      = psel_in & penable_in;
  wire logic wr       = acc & pwrite_in;
  wire logic rd       = acc & ~pwrite_in;
  wire logic setup_rd = psel_in & ~penable_in & ~pwrite_in;
  wire logic hit_ie  = (paddr_in == `WKID_ADDR_IRQ_ENABLE);
  wire logic hit_wc  = (paddr_in == `WKID_ADDR_WAKE_CTRL);
  wire logic hit_fl  = (paddr_in == `WKID_ADDR_FLAGS);
  wire logic hit_st  = (paddr_in == `WKID_ADDR_STATUS);
  wire logic hit_mk  = (paddr_in == `WKID_ADDR_MASK);
  wire logic hit_md  = (paddr_in == `WKID_ADDR_MODE);
  wire logic mapped  = hit_ie | hit_wc | hit_fl | hit_st | hit_mk | hit_md;

  // Ext flag set: idle or active with enable, never sleep
  // ext flag gating
  wire logic ext_ok  = ext_pin_irq_enable & ~in_sleep;
  wire logic tmr_ok  = events_in.timer_overflow & timer_overflow_irq_enable & ~in_sleep;
  // port flag only with irq enable
  wire logic pc_flag = events_in.port_change & port_change_irq_enable;
  // port wake needs wake enable while asleep
  wire logic pc_wake = events_in.port_change & port_change_wake_enable & asleep;

  // Flag set terms: pin1 only flags when awake, else pin0
  // pin0 or pin1 flag
  wire logic set_ext0 = ext_ok & (events_in.ext_pin_0 | (in_idle & ext_evt));
  wire logic set_ext1 = ext_ok & ~in_idle & events_in.ext_pin_1;
  wire logic [3:0] set_vec = {set_ext1, set_ext0, pc_flag, tmr_ok};

  // Wake: idle for ext/timer, sleep or idle for port change
  // idle wake
  wire logic wake_now = (in_idle & ((ext_ok & ext_evt) | tmr_ok)) | pc_wake;

  // Vector only when the source also flags and gie is on
  // vector selection
  wire logic vec_src = (ext_ok & ext_evt) | tmr_ok
                     | (pc_flag & (~asleep | port_change_wake_enable));
  wire logic vec_now = gie & vec_src;
  wire logic dispatch_now = asleep ? wake_now : vec_src;

  wire logic [7:0] next_rd =
      hit_ie ? irq_enable :
      hit_wc ? wake_ctrl :
      hit_fl ? {4'h0, flags} :
      hit_st ? {4'h0, status} :
      hit_mk ? {4'h0, mask} :
      hit_md ? {5'h00, gie, green, asleep} : 8'h00;

  assign pready_out  = 1'b1;
  assign pslverr_out = acc & ~mapped;
  assign irq_out     = |(status & mask);
  // clocks halt in sleep and idle
  assign osc_run_out   = ~asleep;
  assign timer_run_out = ~asleep;

  // Software register writes
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_enable <= `WKID_RESET_BYTE;
      wake_ctrl  <= `WKID_RESET_BYTE;
      mask       <= 4'h0;
      gie        <= 1'b0;
      green      <= 1'b0;
    end else if (wr) begin
      if (hit_ie) irq_enable <= pwdata_in[7:0];
      if (hit_wc) wake_ctrl <= pwdata_in[7:0];
      if (hit_mk) mask <= pwdata_in[3:0];
      if (hit_md) begin
        gie   <= pwdata_in[`WKID_BIT_MODE_GIE];
        green <= pwdata_in[1];
      end
    end
  end

  // Sticky flags; set wins over software clear
  // sticky until cleared
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      flags  <= 4'h0;
      status <= 4'h0;
    end else begin
      flags  <= ((wr && hit_fl) ? (flags & ~pwdata_in[3:0]) : flags) | set_vec;
      // Read clears only the bits that were reported, so a late event survives
      status <= ((rd && hit_st) ? (status & ~prdata_out[3:0]) : status) | set_vec;
    end
  end

  // Power mode sequencing
  // sleep entry and resume
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mode <= WKID_NORMAL;
    end else if (asleep && wake_now) begin
      mode <= green ? WKID_GREEN : WKID_NORMAL;
    end else if (!asleep && sleep_op_in) begin
      mode <= WKID_SLEEP;
    end else if (!asleep && idle_op_in) begin
      mode <= WKID_IDLE;
    end else if (!asleep) begin
      mode <= green ? WKID_GREEN : WKID_NORMAL;
    end
  end

  // Registered dispatch outputs; held until core acknowledges or a newer dispatch replaces them
  // next or vector 0x08
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dispatch_out <= '0;
      prdata_out   <= 32'h0000_0000;
    end else begin
      // Latched at setup so the word already stands at the access edge
      prdata_out <= setup_rd ? {24'h00_0000, next_rd} : prdata_out;
      if (dispatch_now) begin
        dispatch_out.wake        <= asleep;
        dispatch_out.take_vector <= vec_now;
        dispatch_out.vector      <= vec_now ? `WKID_VECTOR_ADDR : 8'h00;
      end else if (resume_in) begin
        dispatch_out <= '0;
      end
    end
  end

  // Checks
  // Port change while powered down with its wake enable set
  sequence seq_port_wake_evt;
    asleep && port_change_wake_enable && events_in.port_change;
  endsequence

  // Dispatch word offered to the core and not yet consumed
  sequence seq_dispatch_open;
    (dispatch_out.wake || dispatch_out.take_vector) && !resume_in && !dispatch_now;
  endsequence

  // Port change while awake with its interrupt enabled
  sequence seq_port_irq_awake;
    !asleep && port_change_irq_enable && events_in.port_change;
  endsequence

  chk_port_silent: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (asleep && !port_change_wake_enable && !port_change_irq_enable && !wr
     && events_in.port_change && !ext_evt && !events_in.timer_overflow)
    |=> (flags[`WKID_BIT_F_PC] == $past(flags[`WKID_BIT_F_PC])) && asleep)
    else $error("port change acted with enables off");

  chk_port_wake: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    seq_port_wake_evt ##0 (!port_change_irq_enable && !wr)
    |=> dispatch_out.wake && !asleep
        && (flags[`WKID_BIT_F_PC] == $past(flags[`WKID_BIT_F_PC])))
    else $error("port change wake missing");

  chk_port_next: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    seq_port_wake_evt ##0 (!gie && port_change_irq_enable)
    |=> dispatch_out.wake && !dispatch_out.take_vector && flags[`WKID_BIT_F_PC])
    else $error("port change resume wrong");

  chk_port_vec: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    seq_port_wake_evt ##0 (gie && port_change_irq_enable)
    |=> dispatch_out.take_vector && dispatch_out.vector == `WKID_VECTOR_ADDR
        && flags[`WKID_BIT_F_PC])
    else $error("port change vector missing");

  chk_port_flag: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (in_sleep && !port_change_wake_enable && port_change_irq_enable
     && events_in.port_change) |=> flags[`WKID_BIT_F_PC] && in_sleep)
    else $error("port flag or sleep wrong");

  // awake, port irq off: flag untouched
  chk_port_quiet: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (!asleep && !port_change_irq_enable && events_in.port_change && !wr)
    |=> flags[`WKID_BIT_F_PC] == $past(flags[`WKID_BIT_F_PC]))
    else $error("port flag set with irq off");

  // awake, gie off: flag, no vector
  chk_port_awake: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    seq_port_irq_awake ##0 !gie
    |=> flags[`WKID_BIT_F_PC] && !dispatch_out.take_vector)
    else $error("awake port flag wrong");

  chk_port_avec: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    seq_port_irq_awake ##0 gie
    |=> dispatch_out.take_vector && dispatch_out.vector == `WKID_VECTOR_ADDR
        && flags[`WKID_BIT_F_PC])
    else $error("awake port vector missing");

  chk_sleep_timer: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (in_sleep && events_in.timer_overflow && !events_in.port_change)
    |=> in_sleep)
    else $error("timer woke from sleep");

  chk_sleep_ext: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (in_sleep && ext_evt && !events_in.port_change && !wr)
    |=> in_sleep && (flags[`WKID_BIT_F_EXT1:`WKID_BIT_F_EXT0]
                     == $past(flags[`WKID_BIT_F_EXT1:`WKID_BIT_F_EXT0])))
    else $error("ext pin acted in sleep");

  chk_timer_vec: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (in_idle && gie && timer_overflow_irq_enable && events_in.timer_overflow)
    |=> dispatch_out.wake && dispatch_out.take_vector && flags[`WKID_BIT_F_TMR])
    else $error("timer idle vector missing");

  chk_timer_next: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (in_idle && !gie && timer_overflow_irq_enable && events_in.timer_overflow)
    |=> dispatch_out.wake && !dispatch_out.take_vector && flags[`WKID_BIT_F_TMR])
    else $error("timer idle wake wrong");

  chk_ext_next: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (in_idle && !gie && ext_pin_irq_enable && events_in.ext_pin_0)
    |=> dispatch_out.wake && !dispatch_out.take_vector && flags[`WKID_BIT_F_EXT0])
    else $error("ext idle wake wrong");

  chk_ext_vec: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (!in_sleep && gie && ext_pin_irq_enable && events_in.ext_pin_0)
    |=> dispatch_out.take_vector && dispatch_out.vector == `WKID_VECTOR_ADDR
        && flags[`WKID_BIT_F_EXT0])
    else $error("ext vector missing");

  chk_ext_pin1: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (!asleep && ext_pin_irq_enable && events_in.ext_pin_1)
    |=> flags[`WKID_BIT_F_EXT1])
    else $error("pin1 flag missing");

  chk_flag_hold: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (flags[`WKID_BIT_F_TMR] && !(wr && hit_fl && pwdata_in[0]))
    |=> flags[`WKID_BIT_F_TMR])
    else $error("flag dropped without clear");

  chk_flag_clear: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (wr && hit_fl && set_vec == 4'h0)
    |=> (flags & $past(pwdata_in[3:0])) == 4'h0)
    else $error("flag clear ignored");

  // Status read clears what was reported
  chk_status_clear: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (rd && hit_st && set_vec == 4'h0)
    |=> (status & $past(prdata_out[3:0])) == 4'h0)
    else $error("status read did not clear");

  chk_dispatch_hold: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    seq_dispatch_open |=> $stable(dispatch_out))
    else $error("dispatch changed before resume");

  chk_dispatch_drop: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (resume_in && !dispatch_now) |=> dispatch_out == '0)
    else $error("dispatch kept after resume");

  chk_wake_mode: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (asleep && wake_now) |=> !asleep)
    else $error("wake left core asleep");

  chk_sleep_entry: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    (!asleep && sleep_op_in) |=> in_sleep && !osc_run_out && !timer_run_out)
    else $error("sleep entry wrong");

  chk_osc_stop: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    $rose(asleep) |-> !osc_run_out && !timer_run_out)
    else $error("clocks run in sleep");
endmodule : wkid_dispatch
`default_nettype wire

// ===== hw/wkid_pkg.sv
// Types for the wake-up and interrupt dispatch block
package wkid_pkg;
  typedef enum logic [1:0] {
    WKID_NORMAL = 2'b00,
    WKID_GREEN  = 2'b01,
    WKID_IDLE   = 2'b11,
    WKID_SLEEP  = 2'b10
  } wkid_mode_e;
  typedef struct packed {
    logic ext_pin_0;
    logic ext_pin_1;
    logic port_change;
    logic timer_overflow;
  } wkid_events_s;
  typedef struct packed {
    logic       wake;
    logic       take_vector;
    logic [7:0] vector;
  } wkid_dispatch_s;
endpackage : wkid_pkg

// ===== verif/tb_top.sv
// Self-checking bench for the wake-up and interrupt dispatch block
`timescale 1ns/10ps
`default_nettype none
`include "wkid_defines.svh"
module tb_top
  import wkid_pkg::*;
;
  logic           core_clk = 1'h0;
  logic           arst_n = 1'h0;
  logic           psel = 1'h0;
  logic           penable = 1'h0;
  logic           pwrite = 1'h0;
  logic           go = 1'h0;
  logic           busy = 1'h0;
  logic [11:0]    paddr = 12'h000;
  logic [31:0]    pwdata = 32'h0;
  logic [31:0]    prdata, rd;
  logic           pready, pslverr, osc_run, timer_run, irq, sleep_op, idle_op, resume, err;
  logic [3:0]     m;
  wkid_events_s   events = '0;
  wkid_mode_e     mode = WKID_NORMAL;
  wkid_dispatch_s dispatch;
  wkid_dispatch_s notes[$];
  int             mismatches = 0;
  int             n_checks = 0;
  int             cycles = 0;
  always #4 core_clk = ~core_clk;
  wkid_dispatch DUT (.core_clk_in(core_clk), .arst_n_in(arst_n), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .events_in(events),
    .sleep_op_in(sleep_op), .idle_op_in(idle_op), .resume_in(resume),
    .dispatch_out(dispatch), .osc_run_out(osc_run), .timer_run_out(timer_run), .irq_out(irq));
  wkid_core_model core (.clk_in(core_clk), .rst_n_in(arst_n), .go_in(go), .mode_in(mode),
    .dispatch_in(dispatch), .sleep_op_out(sleep_op), .idle_op_out(idle_op),
    .resume_out(resume));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  // One APB transfer; the read word stands from setup and is taken at the access edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    @(posedge core_clk);
    while (pready !== 1'h1) @(posedge core_clk);
    err = pslverr;
    rd = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  // Fresh dispatch against the oldest note; also the hang limit
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop();
    end
    if ((dispatch.wake | dispatch.take_vector) !== 1'h1) busy <= 1'h0;
    else if (!busy) begin
      busy <= 1'h1;
      if (notes.size() == 0) chk(dispatch, 32'hffffffff);
      else chk(dispatch, notes.pop_front());
    end
  end
  // One case: fresh reset, enables, mode, one event, then outcome
  task run(input wkid_mode_e md, input logic [7:0] ie, input logic [7:0] we, input logic g,
           input logic [3:0] ev, input logic [3:0] fl, input logic wk, input logic vc);
    @(posedge core_clk);
    arst_n <= 1'h0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'h1;
    m = 4'($urandom);
    apb(1'h1, `WKID_ADDR_IRQ_ENABLE, {24'h0, ie});
    apb(1'h1, `WKID_ADDR_WAKE_CTRL, {24'h0, we});
    apb(1'h1, `WKID_ADDR_MASK, {28'h0, m});
    apb(1'h1, `WKID_ADDR_MODE, {29'h0, g, md == WKID_GREEN, 1'h0});
    mode <= md;
    go <= 1'h1;
    @(posedge core_clk);
    go <= 1'h0;
    repeat (3) @(posedge core_clk);
    if (wk | vc) notes.push_back({wk, vc, vc ? `WKID_VECTOR_ADDR : 8'h00});
    events <= ev;
    @(posedge core_clk);
    events <= '0;
    repeat (8) @(posedge core_clk);
    #1;
    if (!wk) chk({osc_run, timer_run}, {2{md == WKID_NORMAL || md == WKID_GREEN}});
    chk(irq, |(fl & m));
    apb(1'h0, `WKID_ADDR_STATUS, 32'h0);
    chk(rd, fl);
    // Status clears at the access edge and irq drops with it; irq is checked at the next edge
    @(posedge core_clk);
    chk(irq, 1'h0);
    apb(1'h0, `WKID_ADDR_FLAGS, 32'h0);
    chk(rd, fl);
  endtask : run
  initial begin
    rd = $urandom(53);
    repeat (20) @(posedge core_clk);
    arst_n <= 1'h1;
    apb(1'h0, `WKID_ADDR_IRQ_ENABLE, 32'h0);
    chk(rd, 32'h0);
    apb(1'h0, 12'h020, 32'h0);
    chk(err, 1'h1);
    run(WKID_IDLE,   8'h04, 8'h00, 1'h0, 4'h8, 4'h4, 1'h1, 1'h0);
    run(WKID_NORMAL, 8'h04, 8'h00, 1'h0, 4'h8, 4'h4, 1'h0, 1'h0);
    run(WKID_NORMAL, 8'h04, 8'h00, 1'h1, 4'h8, 4'h4, 1'h0, 1'h1);
    run(WKID_IDLE,   8'h04, 8'h00, 1'h1, 4'h4, 4'h4, 1'h1, 1'h1);
    run(WKID_GREEN,  8'h04, 8'h00, 1'h0, 4'h4, 4'h8, 1'h0, 1'h0);
    run(WKID_SLEEP,  8'h00, 8'h00, 1'h0, 4'h2, 4'h0, 1'h0, 1'h0);
    run(WKID_NORMAL, 8'h00, 8'h10, 1'h1, 4'h2, 4'h0, 1'h0, 1'h0);
    run(WKID_IDLE,   8'h02, 8'h00, 1'h1, 4'h2, 4'h2, 1'h0, 1'h0);
    run(WKID_SLEEP,  8'h00, 8'h10, 1'h1, 4'h2, 4'h0, 1'h1, 1'h0);
    run(WKID_SLEEP,  8'h02, 8'h10, 1'h0, 4'h2, 4'h2, 1'h1, 1'h0);
    run(WKID_IDLE,   8'h02, 8'h10, 1'h1, 4'h2, 4'h2, 1'h1, 1'h1);
    run(WKID_GREEN,  8'h02, 8'h00, 1'h0, 4'h2, 4'h2, 1'h0, 1'h0);
    run(WKID_NORMAL, 8'h02, 8'h00, 1'h1, 4'h2, 4'h2, 1'h0, 1'h1);
    run(WKID_IDLE,   8'h01, 8'h00, 1'h0, 4'h1, 4'h1, 1'h1, 1'h0);
    run(WKID_GREEN,  8'h01, 8'h00, 1'h1, 4'h1, 4'h1, 1'h0, 1'h1);
    run(WKID_IDLE,   8'h01, 8'h00, 1'h1, 4'h1, 4'h1, 1'h1, 1'h1);
    run(WKID_SLEEP,  8'h05, 8'h00, 1'h1, 4'h9, 4'h0, 1'h0, 1'h0);
    repeat (10) @(posedge core_clk);
    chk(notes.size(), 32'h0);
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire

// ===== verif/wkid_core_model.sv
// Core sequencer model: power-down requests and dispatch hand-back
`timescale 1ns/10ps
`default_nettype none
module wkid_core_model
  import wkid_pkg::*;
(
  input  wire logic           clk_in,
  input  wire logic           rst_n_in,
  input  wire logic           go_in,
  input  wire wkid_mode_e     mode_in,
  input  wire wkid_dispatch_s dispatch_in,
  output logic                sleep_op_out,
  output logic                idle_op_out,
  output logic                resume_out
);
  logic     pend;
  logic     slow;
  int       cnt;
  // consume dispatch, alternating prompt and slow
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sleep_op_out <= 1'h0;
      idle_op_out  <= 1'h0;
      resume_out   <= 1'h0;
      pend         <= 1'h0;
      slow         <= 1'h0;
      cnt          <= 0;
    end else begin
      sleep_op_out <= go_in && mode_in == WKID_SLEEP;
      idle_op_out  <= go_in && mode_in == WKID_IDLE;
      if (resume_out) begin
        resume_out <= 1'h0;
      end else if (pend) begin
        // Slow answers would stretch the hold-until-resume path, but the bench resets before each one-dispatch case, so every answer is prompt
        if (cnt == 0) begin
          resume_out <= 1'h1;
          pend       <= 1'h0;
          slow       <= !slow;
        end else begin
          cnt <= cnt - 1;
        end
      end else if ((dispatch_in.wake | dispatch_in.take_vector) === 1'h1) begin
        pend <= 1'h1;
        cnt  <= slow ? 3 : 0;
      end
    end
  end
endmodule : wkid_core_model
`default_nettype wire
